// ===== design/dmp_defines.svh
`ifndef DMP_DEFINES_SVH
`define DMP_DEFINES_SVH
// register byte offsets
`define DMP_OFS_OUT_DATA   8'h00
`define DMP_OFS_OUT_CFG    8'h04
`define DMP_OFS_IN_CFG     8'h08
`define DMP_OFS_IN_STATE   8'h0c
`define DMP_OFS_IRQ_STAT   8'h10
`define DMP_OFS_IRQ_MASK   8'h14
`define DMP_OFS_CH_CTRL    8'h18
`define DMP_OFS_TX_A       8'h1c
`define DMP_OFS_TX_B       8'h20
`define DMP_OFS_RX_A       8'h24
`define DMP_OFS_RX_B       8'h28
`define DMP_OFS_CT         8'h2c
// field positions
`define DMP_CH_CTRL_STRIDE 8
`define DMP_CT_STOP_BIT    16
`define DMP_IRQ_RX         0
`define DMP_IRQ_TX         2
`define DMP_IRQ_CT         4
// reset values
`define DMP_RST_OUT_DATA   8'hff
// timing: ref_clk cycles per 16x tick
`define DMP_BAUD_DIV       16
`endif

// ===== design/dmp_pkg.sv
package dmp_pkg;
  typedef struct packed {
    logic [1:0] op67Sel;
    logic [1:0] op5Sel;
    logic [1:0] op4Sel;
    logic [1:0] op3Sel;
    logic [1:0] op2Sel;
    logic [1:0] rtsSel;
  } dmp_outcfg_t;
  typedef struct packed {
    logic [1:0] rxExt;
    logic [1:0] txExt;
    logic       ctExt;
    logic [1:0] ctsEn;
  } dmp_incfg_t;
  typedef struct packed {
    logic autoTx;
    logic autoRx;
    logic rtsOn;
    logic loopback;
    logic txEn;
  } dmp_chctrl_t;
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } dmp_outport_t;
  typedef enum logic [1:0] {SER_IDLE, SER_DATA, SER_STOP} dmp_ser_t;
endpackage : dmp_pkg

// ===== design/dmp_pins.sv
// Notes on behaviour
// - transmit sends LSB first; mark is high, space is low.
// - transmit line held at mark when disabled, idle or in local loopback.
// - out bits 0,1 are outputs or active-low RTS A/B, auto-deassertable.
// - out bit 2 is output, tx A 1x/16x clock, or rx A 1x clock.
// - out bit 3 is output, open-drain timer irq, tx B or rx B 1x clock.
// - out bits 4,5 are outputs or open-drain rx-ready/fifo-full irq A/B; the code drives overrun in place of fifo-full.
// - out bits 6,7 are outputs or open-drain tx-ready irq A/B.
// - in bits 0,1 are inputs or active-low CTS A/B.
// - in bit 2 is input or external timer clock.
// - in bits 3,5 are external tx clocks; data changes on falling edge.
// - in bits 4,6 are external rx clocks; data sampled on rising edge.
// - reset drives all out bits high, stops timer, transmit at mark.
// - receive takes first bit as LSB; high is mark, low is space.
//
// The APB slave port and the register addresses are this design's own decisions.
`include "dmp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dmp_pins #(
  parameter int BAUD_DIV = `DMP_BAUD_DIV
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial lines
  input  wire logic        serial_in_chan_a,
  input  wire logic        serial_in_chan_b,
  output logic             serial_out_chan_a,
  output logic             serial_out_chan_b,
  // input port pins
  input  wire logic        inport_bit0,
  input  wire logic        inport_bit1,
  input  wire logic        inport_bit2,
  input  wire logic        inport_bit3,
  input  wire logic        inport_bit4,
  input  wire logic        inport_bit5,
  input  wire logic        inport_bit6,
  // output port pins: level and enable
  output dmp_pkg::dmp_outport_t outport,
  // interrupt
  output logic             irq
);
  import dmp_pkg::*;

  localparam int PW = $clog2(BAUD_DIV);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic [8:0]  pinMeta_reg, pinSync_reg, pinLast_reg;
  logic [6:0]  inSync;
  logic [PW-1:0] presc_reg;
  logic [3:0]  phase_reg;
  logic        tick16, tick1x, clk16Out, clk1xOut;
  logic [7:0]  outData_reg;
  dmp_outcfg_t outCfg_reg;
  dmp_incfg_t  inCfg_reg;
  dmp_chctrl_t chCtrl_reg [2];
  logic [4:0]  irqStat_reg, irqMask_reg, irqSet;
  logic [15:0] ctReload_reg, ctCount_reg;
  logic        ctRun_reg, ctTick, ctDone;
  logic [31:0] prdata_reg;
  logic        slvErr_reg;
  logic        setup, access, wrAcc, rdAcc, hit;
  logic        wrTx [2];
  logic        rdRx [2];
  logic        holdValid [2];
  logic        rxValid [2];
  logic        overrun [2];
  logic        txLine [2];
  logic        txTaken [2];
  logic        txIdle [2];
  logic        rxDone [2];
  logic        extTxLvl [2];
  logic        extRxLvl [2];
  logic [7:0]  rxData [2];
  logic        serOut_reg [2];
  dmp_outport_t pins_next, pins_reg;

  // two-flop synchronisers, third stage for edge finding
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_reg <= 9'h1ff;
      pinSync_reg <= 9'h1ff;
      pinLast_reg <= 9'h1ff;
    end else begin
      pinMeta_reg <= {serial_in_chan_b, serial_in_chan_a, inport_bit6, inport_bit5,
                      inport_bit4, inport_bit3, inport_bit2, inport_bit1, inport_bit0};
      pinSync_reg <= pinMeta_reg;
      pinLast_reg <= pinSync_reg;
    end
  end
  assign inSync = pinSync_reg[6:0];

  // internal baud: 16x tick and 1x tick
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      presc_reg <= '0;
      phase_reg <= 4'h0;
    end else begin
      presc_reg <= tick16 ? '0 : presc_reg + 1'b1;
      if (tick16)
        phase_reg <= phase_reg + 4'h1;
    end
  end
  assign tick16   = (presc_reg == PW'(BAUD_DIV - 1));
  assign tick1x   = tick16 && (phase_reg == 4'hf);
  assign clk16Out = (presc_reg < PW'(BAUD_DIV / 2));
  assign clk1xOut = ~phase_reg[3];

  // apb: data latched in setup, answer in first access cycle
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wrAcc  = access && pwrite && !slvErr_reg;
  assign rdAcc  = access && !pwrite && !slvErr_reg;
  assign pready  = access;
  assign pslverr = access && slvErr_reg;
  assign prdata  = prdata_reg;
  assign wrTx[0] = wrAcc && (paddr == `DMP_OFS_TX_A);
  assign wrTx[1] = wrAcc && (paddr == `DMP_OFS_TX_B);
  assign rdRx[0] = rdAcc && (paddr == `DMP_OFS_RX_A);
  assign rdRx[1] = rdAcc && (paddr == `DMP_OFS_RX_B);

  always_comb begin
    unique case (paddr)
      `DMP_OFS_OUT_DATA, `DMP_OFS_OUT_CFG, `DMP_OFS_IN_CFG, `DMP_OFS_IN_STATE,
      `DMP_OFS_IRQ_STAT, `DMP_OFS_IRQ_MASK, `DMP_OFS_CH_CTRL, `DMP_OFS_TX_A,
      `DMP_OFS_TX_B, `DMP_OFS_RX_A, `DMP_OFS_RX_B, `DMP_OFS_CT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= 32'h0;
      slvErr_reg <= 1'b0;
    end else if (setup) begin
      slvErr_reg <= !hit;
      prdata_reg <= 32'h0;
      unique case (paddr)
        `DMP_OFS_OUT_DATA: prdata_reg <= {24'h0, outData_reg};
        `DMP_OFS_OUT_CFG:  prdata_reg <= {20'h0, outCfg_reg};
        `DMP_OFS_IN_CFG:   prdata_reg <= {25'h0, inCfg_reg};
        `DMP_OFS_IN_STATE: prdata_reg <= {25'h0, inSync};
        `DMP_OFS_IRQ_STAT: prdata_reg <= {27'h0, irqStat_reg};
        `DMP_OFS_IRQ_MASK: prdata_reg <= {27'h0, irqMask_reg};
        `DMP_OFS_CH_CTRL:  prdata_reg <= {19'h0, chCtrl_reg[1], 3'h0, chCtrl_reg[0]};
        `DMP_OFS_TX_A:     prdata_reg <= {31'h0, holdValid[0]};
        `DMP_OFS_TX_B:     prdata_reg <= {31'h0, holdValid[1]};
        `DMP_OFS_RX_A:     prdata_reg <= {22'h0, overrun[0], rxValid[0], rxData[0]};
        `DMP_OFS_RX_B:     prdata_reg <= {22'h0, overrun[1], rxValid[1], rxData[1]};
        `DMP_OFS_CT:       prdata_reg <= {15'h0, ctRun_reg, ctCount_reg};
        default:           prdata_reg <= 32'h0;
      endcase
    end
  end

  // software-written configuration
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      outData_reg <= `DMP_RST_OUT_DATA;
      outCfg_reg  <= '0;
      inCfg_reg   <= '0;
      irqMask_reg <= 5'h00;
    end else if (wrAcc) begin
      if (paddr == `DMP_OFS_OUT_DATA)
        outData_reg <= pwdata[7:0];
      if (paddr == `DMP_OFS_OUT_CFG)
        outCfg_reg <= pwdata[$bits(dmp_outcfg_t)-1:0];
      if (paddr == `DMP_OFS_IN_CFG)
        inCfg_reg <= pwdata[$bits(dmp_incfg_t)-1:0];
      if (paddr == `DMP_OFS_IRQ_MASK)
        irqMask_reg <= pwdata[4:0];
    end
  end

  // channel control, rts auto-deassert on rx arrival or tx drain
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chCtrl_reg[0] <= '0;
      chCtrl_reg[1] <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wrAcc && paddr == `DMP_OFS_CH_CTRL)
          chCtrl_reg[c] <= pwdata[c*`DMP_CH_CTRL_STRIDE +: $bits(dmp_chctrl_t)];
        else if ((chCtrl_reg[c].autoRx && rxDone[c]) ||
                 (chCtrl_reg[c].autoTx && txIdle[c] && !holdValid[c]))
          chCtrl_reg[c].rtsOn <= 1'b0;
      end
    end
  end

  // counter/timer: stopped by reset, clock from 16x tick or in bit 2
  assign ctTick = inCfg_reg.ctExt ? (pinSync_reg[2] && !pinLast_reg[2]) : tick16;
  assign ctDone = ctRun_reg && ctTick && (ctCount_reg == 16'h0001);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctRun_reg    <= 1'b0;
      ctReload_reg <= 16'h0000;
      ctCount_reg  <= 16'h0000;
    end else if (wrAcc && paddr == `DMP_OFS_CT) begin
      ctRun_reg    <= !pwdata[`DMP_CT_STOP_BIT];
      ctReload_reg <= pwdata[15:0];
      ctCount_reg  <= pwdata[15:0];
    end else if (ctRun_reg && ctTick) begin
      ctCount_reg <= ctDone ? ctReload_reg : ctCount_reg - 16'h0001;
    end
  end

  // interrupt status: write one to clear, a new event wins
  assign irqSet = {ctDone, txTaken[1], txTaken[0], rxDone[1], rxDone[0]};
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      irqStat_reg <= 5'h00;
    else
      irqStat_reg <= (irqStat_reg & ~((wrAcc && paddr == `DMP_OFS_IRQ_STAT) ?
                      pwdata[4:0] : 5'h00)) | irqSet;
  end
  assign irq = |(irqStat_reg & irqMask_reg);

  // serial channels
  for (genvar g = 0; g < 2; g++) begin : gCh
    localparam int TXC = (g == 0) ? 3 : 5;
    localparam int RXC = (g == 0) ? 4 : 6;
    dmp_ser_t   txState_reg, rxState_reg;
    logic [2:0] txCnt_reg, rxCnt_reg;
    logic [7:0] txShift_reg, txHold_reg, rxShift_reg;
    logic       txTick, rxTick, rxBit, ctsOk;

    // ext tx clock falling edge, ext rx clock rising edge
    assign txTick = inCfg_reg.txExt[g] ? (!pinSync_reg[TXC] && pinLast_reg[TXC]) : tick1x;
    assign rxTick = inCfg_reg.rxExt[g] ? (pinSync_reg[RXC] && !pinLast_reg[RXC]) : tick1x;
    assign ctsOk  = !inCfg_reg.ctsEn[g] || !inSync[g];
    assign rxBit  = chCtrl_reg[g].loopback ? txLine[g] : pinSync_reg[7+g];
    assign txTaken[g]  = txTick && txState_reg == SER_IDLE && holdValid[g] &&
                         chCtrl_reg[g].txEn && ctsOk;
    assign txIdle[g]   = txState_reg == SER_IDLE;
    assign rxDone[g]   = rxTick && rxState_reg == SER_STOP && rxBit;
    assign extTxLvl[g] = pinSync_reg[TXC];
    assign extRxLvl[g] = pinSync_reg[RXC];

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        holdValid[g] <= 1'b0;
        txHold_reg   <= 8'h00;
      end else if (wrTx[g]) begin
        holdValid[g] <= 1'b1;
        txHold_reg   <= pwdata[7:0];
      end else if (txTaken[g]) begin
        holdValid[g] <= 1'b0;
      end
    end

    // start bit, eight data bits lsb first, one stop bit
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        txState_reg <= SER_IDLE;
        txCnt_reg   <= 3'h0;
        txShift_reg <= 8'h00;
        txLine[g]   <= 1'b1;
      end else if (txTick) begin
        unique case (txState_reg)
          SER_IDLE: if (txTaken[g]) begin
            txLine[g]   <= 1'b0;
            txShift_reg <= txHold_reg;
            txCnt_reg   <= 3'h0;
            txState_reg <= SER_DATA;
          end
          SER_DATA: begin
            txLine[g]   <= txShift_reg[0];
            txShift_reg <= {1'b0, txShift_reg[7:1]};
            txCnt_reg   <= txCnt_reg + 3'h1;
            if (txCnt_reg == 3'h7)
              txState_reg <= SER_STOP;
          end
          SER_STOP: begin
            txLine[g]   <= 1'b1;
            txState_reg <= SER_IDLE;
          end
        endcase
      end
    end

    // line forced to mark when disabled or looped back
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
        serOut_reg[g] <= 1'b1;
      else
        serOut_reg[g] <= (chCtrl_reg[g].txEn && !chCtrl_reg[g].loopback) ?
                         txLine[g] : 1'b1;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        rxState_reg <= SER_IDLE;
        rxCnt_reg   <= 3'h0;
        rxShift_reg <= 8'h00;
      end else if (rxTick) begin
        unique case (rxState_reg)
          SER_IDLE: if (!rxBit) begin
            rxCnt_reg   <= 3'h0;
            rxState_reg <= SER_DATA;
          end
          SER_DATA: begin
            rxShift_reg <= {rxBit, rxShift_reg[7:1]};
            rxCnt_reg   <= rxCnt_reg + 3'h1;
            if (rxCnt_reg == 3'h7)
              rxState_reg <= SER_STOP;
          end
          SER_STOP: rxState_reg <= SER_IDLE;
        endcase
      end
    end

    // receive holding: arrival wins over a read that clears it
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        rxValid[g] <= 1'b0;
        overrun[g] <= 1'b0;
        rxData[g]  <= 8'h00;
      end else if (rxDone[g]) begin
        rxValid[g] <= 1'b1;
        overrun[g] <= overrun[g] || (rxValid[g] && !rdRx[g]);
        rxData[g]  <= rxShift_reg;
      end else if (rdRx[g]) begin
        rxValid[g] <= 1'b0;
        overrun[g] <= 1'b0;
      end
    end

    tx_mark_idle_a: assert property ((!chCtrl_reg[g].txEn || chCtrl_reg[g].loopback)
        |=> serOut_reg[g]) else $error("serial out not at mark");
    tx_ext_fall_a: assert property (inCfg_reg.txExt[g] && $changed(txLine[g])
        |-> $past(!pinSync_reg[TXC] && pinLast_reg[TXC])) else $error("tx bit off edge");
    rx_ext_rise_a: assert property ((inCfg_reg.rxExt[g] && rxTick)
        |-> $rose(pinSync_reg[RXC])) else $error("rx sample off edge");
  end

  assign serial_out_chan_a = serOut_reg[0];
  assign serial_out_chan_b = serOut_reg[1];

  // pin function mux; open drain drives low only
  always_comb begin
    pins_next.level = outData_reg;
    pins_next.oe    = 8'hff;
    for (int c = 0; c < 2; c++) begin
      if (outCfg_reg.rtsSel[c])
        pins_next.level[c] = !chCtrl_reg[c].rtsOn;
      if (outCfg_reg.op67Sel[c]) begin
        pins_next.level[6+c] = 1'b0;
        pins_next.oe[6+c]    = !holdValid[c] && chCtrl_reg[c].txEn;
      end
    end
    unique case (outCfg_reg.op2Sel)
      2'h0: pins_next.level[2] = outData_reg[2];
      2'h1: pins_next.level[2] = inCfg_reg.txExt[0] ? extTxLvl[0] : clk16Out;
      2'h2: pins_next.level[2] = inCfg_reg.txExt[0] ? extTxLvl[0] : clk1xOut;
      2'h3: pins_next.level[2] = inCfg_reg.rxExt[0] ? extRxLvl[0] : clk1xOut;
    endcase
    unique case (outCfg_reg.op3Sel)
      2'h0: pins_next.level[3] = outData_reg[3];
      2'h1: begin
        pins_next.level[3] = 1'b0;
        pins_next.oe[3]    = irqStat_reg[`DMP_IRQ_CT];
      end
      2'h2: pins_next.level[3] = inCfg_reg.txExt[1] ? extTxLvl[1] : clk1xOut;
      2'h3: pins_next.level[3] = inCfg_reg.rxExt[1] ? extRxLvl[1] : clk1xOut;
    endcase
    if (outCfg_reg.op4Sel == 2'h1 || outCfg_reg.op4Sel == 2'h2) begin
      pins_next.level[4] = 1'b0;
      pins_next.oe[4]    = (outCfg_reg.op4Sel == 2'h1) ? rxValid[0] : overrun[0];
    end
    if (outCfg_reg.op5Sel == 2'h1 || outCfg_reg.op5Sel == 2'h2) begin
      pins_next.level[5] = 1'b0;
      pins_next.oe[5]    = (outCfg_reg.op5Sel == 2'h1) ? rxValid[1] : overrun[1];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins_reg.level <= 8'hff;
      pins_reg.oe    <= 8'hff;
    end else begin
      pins_reg <= pins_next;
    end
  end
  assign outport = pins_reg;

  sequence rtsRaised;
    outCfg_reg.rtsSel[0] && chCtrl_reg[0].rtsOn;
  endsequence
  // pin follows rts one cycle later, so an auto-deassert cannot trip it
  sequence rtsHeld;
    !outport.level[0];
  endsequence

  rts_low_a: assert property (rtsRaised |=> rtsHeld)
    else $error("rts A not low");
  gp_follow_a: assert property (outCfg_reg.op67Sel == 2'h0 ##1 outCfg_reg.op67Sel == 2'h0
    |-> outport.level[7:6] == $past(outData_reg[7:6])) else $error("gp out mismatch");
  od_low_only_a: assert property ((outCfg_reg.op4Sel == 2'h1) ##1 (outCfg_reg.op4Sel == 2'h1)
    |-> !outport.level[4] && outport.oe[4] == $past(rxValid[0])) else $error("od pin");
  ct_irq_pin_a: assert property ((outCfg_reg.op3Sel == 2'h1 && irqStat_reg[`DMP_IRQ_CT]) [*2]
    |-> outport.oe[3] && !outport.level[3]) else $error("timer irq pin");
  ct_timer_a: assert property (ctDone |=> irqStat_reg[`DMP_IRQ_CT] &&
    ctCount_reg == ctReload_reg) else $error("timer reload");
  rx_lsb_a: assert property (rxDone[0] |=> rxData[0] == $past(gCh[0].rxShift_reg))
    else $error("rx byte");
  tx_lsb_a: assert property (txTaken[0] |=> gCh[0].txShift_reg == $past(gCh[0].txHold_reg)
    ##[1:300] (gCh[0].txState_reg == SER_DATA)) else $error("tx load");
endmodule : dmp_pins
`default_nettype wire

// ===== sim/dmp_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module dmp_far_end (
  // block outputs
  input  wire dmp_pkg::dmp_outport_t outport,
  input  wire logic                  serial_out_chan_b,
  // pin levels and link side
  output logic                 [7:0] pinLevel,
  output logic                       serial_in_chan_a,
  output logic                       extTxClkB,
  output logic                       extRxClkA
);
  import dmp_pkg::*;
  logic capQ[$];
  // pull-ups on open-drain and released pins
  assign pinLevel = ~outport.oe | outport.level;
  initial begin
    serial_in_chan_a = 1'b1;
    extTxClkB        = 1'b1;
    extRxClkA        = 1'b1;
  end
  // clocks park high between frames; offset keeps edges off the block clock
  task automatic send_rx_a(input logic [7:0] dv);
    logic [9:0] f;
    f = {1'b1, dv, 1'b0};
    #0.7;
    for (int i = 0; i < 10; i++) begin
      #24 extRxClkA = 1'b0;
      serial_in_chan_a = f[i];
      #24 extRxClkA = 1'b1;
    end
  endtask : send_rx_a
  // line captured just before each fall launches the next bit
  task automatic run_tx_clk_b(input int cnt);
    #0.7;
    repeat (cnt) begin
      #24 capQ.push_back(serial_out_chan_b);
      extTxClkB = 1'b0;
      #24 extTxClkB = 1'b1;
    end
  endtask : run_tx_clk_b
endmodule : dmp_far_end
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmp_defines.svh"
module tb_top;
  import dmp_pkg::*;
  localparam int BD = 4;
  localparam int BIT = BD * 16;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [31:0] CLK_CFG [5] = '{32'h4, 32'h8, 32'hc, 32'h20, 32'h30};
  localparam int CLK_EXP [5] = '{64, 4, 4, 4, 4};
  logic         ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic         irq, serOutA, serOutB, serInA, txClkB, rxClkA, prevBit;
  logic [7:0]   paddr, pin;
  logic [2:0]   inLow;
  logic [31:0]  pwdata, prdata, d;
  dmp_outport_t outport;
  logic [64:0]  expQ[$];
  int           nFail, checksDone, cyc, seed, n, k;

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  dmp_pins #(.BAUD_DIV(BD)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_chan_a(serInA), .serial_in_chan_b(1'b1),
    .serial_out_chan_a(serOutA), .serial_out_chan_b(serOutB),
    .inport_bit0(inLow[0]), .inport_bit1(inLow[1]), .inport_bit2(inLow[2]),
    .inport_bit3(1'b1), .inport_bit4(rxClkA), .inport_bit5(txClkB),
    .inport_bit6(1'b1), .outport(outport), .irq(irq)
  );

  dmp_far_end far (
    .outport(outport), .serial_out_chan_b(serOutB), .pinLevel(pin),
    .serial_in_chan_a(serInA), .extTxClkB(txClkB), .extRxClkA(rxClkA)
  );

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic closeOut;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : closeOut

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nFail++;
      closeOut();
    end
  end

  // each completed read is compared with the oldest note
  always @(posedge ref_clk) begin
    logic [64:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      e = expQ.pop_front();
      check("prdata", prdata & e[63:32], e[31:0] & e[63:32]);
      check("pslverr", {31'h0, pslverr}, {31'h0, e[64]});
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv,
                     input logic [31:0] m, input logic err);
    @(posedge ref_clk);
    if (!wr)
      expQ.push_back({err, m, dv});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dv;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    apb(1'b1, a, dv, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] dv, input logic [31:0] m);
    apb(1'b0, a, dv, m, 1'b0);
  endtask : rd

  task automatic idle(input int c);
    repeat (c) @(negedge ref_clk);
  endtask : idle

  initial begin
    seed = 25;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    inLow = 3'h7;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    idle(2);
    check("pins", pin, 8'hff);
    check("txd", {serOutA, serOutB}, 2'b11);
    check("irq", irq, 1'b0);
    rd(`DMP_OFS_OUT_DATA, 32'hff, ALL);
    rd(`DMP_OFS_CT, 32'h0, 32'h10000);
    apb(1'b0, 8'h3c, 32'h0, ALL, 1'b1);
    repeat (3) begin
      d = $random(seed);
      @(posedge ref_clk);
      inLow <= d[10:8];
      wr(`DMP_OFS_OUT_DATA, d);
      idle(3);
      check("gp out", pin, d[7:0]);
      rd(`DMP_OFS_IN_STATE, {25'h0, 4'hf, d[10:8]}, 32'h7f);
    end
    wr(`DMP_OFS_OUT_CFG, 32'h3);
    wr(`DMP_OFS_CH_CTRL, 32'h404);
    idle(3);
    check("rts on", pin[1:0], 2'b00);
    wr(`DMP_OFS_CH_CTRL, 32'h0);
    idle(3);
    check("rts off", pin[1:0], 2'b11);
    foreach (CLK_CFG[i]) begin
      wr(`DMP_OFS_OUT_CFG, CLK_CFG[i]);
      idle(8);
      n = 0;
      k = CLK_CFG[i][5] ? 3 : 2;
      prevBit = pin[k];
      repeat (4 * BIT) begin
        @(negedge ref_clk);
        if (pin[k] === 1'b1 && prevBit === 1'b0)
          n++;
        prevBit = pin[k];
      end
      check("clk rises", 32'(n >= CLK_EXP[i] - 1 && n <= CLK_EXP[i] + 1), 32'h1);
    end
    wr(`DMP_OFS_OUT_CFG, 32'h401);
    wr(`DMP_OFS_IRQ_MASK, 32'h4);
    wr(`DMP_OFS_CH_CTRL, 32'h5);
    idle(3);
    check("tx ready", pin[6], 1'b0);
    d = $random(seed);
    wr(`DMP_OFS_TX_A, d);
    wr(`DMP_OFS_CH_CTRL, 32'h15);
    idle(3);
    check("rts a", pin[0], 1'b0);
    k = 0;
    while (serOutA !== 1'b0 && k < 3 * BIT) begin
      @(negedge ref_clk);
      k++;
    end
    idle(BIT / 2);
    check("tx a start", serOutA, 1'b0);
    for (int i = 0; i < 9; i++) begin
      idle(BIT);
      check("tx a bit", serOutA, i < 8 ? d[i] : 1'b1);
    end
    idle(BIT);
    check("auto rts", pin[0], 1'b1);
    check("irq set", irq, 1'b1);
    rd(`DMP_OFS_IRQ_STAT, 32'h4, 32'h4);
    wr(`DMP_OFS_IRQ_MASK, 32'h0);
    idle(1);
    check("irq masked", irq, 1'b0);
    wr(`DMP_OFS_IRQ_MASK, 32'h4);
    idle(1);
    check("irq unmasked", irq, 1'b1);
    wr(`DMP_OFS_IRQ_STAT, 32'h4);
    idle(1);
    check("irq cleared", irq, 1'b0);
    wr(`DMP_OFS_CH_CTRL, 32'h3);
    wr(`DMP_OFS_TX_A, 32'h0);
    n = 0;
    repeat (12 * BIT) begin
      @(negedge ref_clk);
      if (serOutA !== 1'b1)
        n++;
    end
    check("loopback mark", n, 0);
    // looped-back zero byte must arrive and be drained before the rx tests
    rd(`DMP_OFS_RX_A, 32'h100, 32'h3ff);
    wr(`DMP_OFS_CH_CTRL, 32'h0);
    wr(`DMP_OFS_IN_CFG, 32'h20);
    wr(`DMP_OFS_OUT_CFG, 32'h40);
    d = $random(seed);
    far.send_rx_a(d[7:0]);
    idle(10);
    check("rx ready", pin[4], 1'b0);
    rd(`DMP_OFS_RX_A, {22'h0, 2'b01, d[7:0]}, 32'h3ff);
    idle(3);
    check("rx ready off", pin[4], 1'b1);
    wr(`DMP_OFS_OUT_CFG, 32'h80);
    far.send_rx_a(d[15:8]);
    far.send_rx_a(d[23:16]);
    idle(10);
    check("overrun", pin[4], 1'b0);
    rd(`DMP_OFS_RX_A, 32'h300, 32'h300);
    idle(3);
    check("overrun off", pin[4], 1'b1);
    wr(`DMP_OFS_IN_CFG, 32'h10);
    wr(`DMP_OFS_CH_CTRL, 32'h100);
    d = $random(seed);
    wr(`DMP_OFS_TX_B, d);
    far.run_tx_clk_b(14);
    k = 0;
    while (k < 14 && far.capQ[k] !== 1'b0)
      k++;
    for (int i = 0; i < 9; i++)
      check("tx b bit", far.capQ[k + 1 + i], i < 8 ? d[i] : 1'b1);
    wr(`DMP_OFS_OUT_CFG, 32'h10);
    wr(`DMP_OFS_CT, 32'h2);
    idle(40);
    check("timer irq pin", pin[3], 1'b0);
    wr(`DMP_OFS_IN_CFG, 32'h4);
    wr(`DMP_OFS_CT, 32'hffff);
    rd(`DMP_OFS_CT, 32'h10000, 32'h10000);
    wr(`DMP_OFS_CT, 32'h10000);
    rd(`DMP_OFS_CT, 32'h0, 32'h10000);
    wr(`DMP_OFS_OUT_DATA, 32'h0);
    wr(`DMP_OFS_CT, 32'h1234);
    @(posedge ref_clk);
    nrst <= 1'b0;
    idle(3);
    check("reset pins", pin, 8'hff);
    check("reset txd", {serOutA, serOutB}, 2'b11);
    @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`DMP_OFS_CT, 32'h0, 32'h10000);
    rd(`DMP_OFS_OUT_DATA, 32'hff, ALL);
    idle(2);
    closeOut();
  end
endmodule : tb_top
`default_nettype wire
